// *** bench/testbench.sv ***
// testbench.sv: self-checking bench for the clock and clear select
// assumes: design and checker compiled first; pins and overflow run free from the bench
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import timer_sel_pkg::*;
    logic [5:0]  ctrl_we, sync_enable, phase_mode, buffer_c, buffer_d, count_tick;
    logic [5:0]  match_a, match_b, match_c, match_d, counter_clear;
    logic [7:0]  ctrl_wdata;
    logic [7:0]  ctrl_rdata [6];
    logic        clk, srst, ovf, ext_a, ext_b, ext_c, ext_d;
    int          cyc, error_cnt, n_checks, ticks, ch, want;
    // rows: phase flag, channel, ctrl byte, tick period in clocks (4 periods counted)
    logic [31:0] rows [] = '{32'h0_0_00_0001, 32'h1_0_00_0001, 32'h0_0_01_0004,
        32'h0_0_0a_0010, 32'h0_0_13_0020, 32'h0_0_04_0014, 32'h0_0_05_001c, 32'h0_0_06_002c,
        32'h0_0_07_0034, 32'h0_1_04_0014, 32'h0_1_05_001c, 32'h0_1_06_0100, 32'h0_1_17_000c,
        32'h0_2_04_0014, 32'h0_2_05_001c, 32'h0_2_06_002c, 32'h0_2_07_0400, 32'h1_2_00_0001,
        32'h0_3_04_0014, 32'h0_3_05_0400, 32'h0_3_06_0100, 32'h0_3_07_1000, 32'h0_3_11_0002,
        32'h0_4_04_0014, 32'h0_4_05_002c, 32'h0_4_06_0400, 32'h0_4_07_000c, 32'h0_5_04_0014,
        32'h0_5_05_002c, 32'h0_5_06_0100, 32'h0_5_07_0034,
        32'h0_5_10_0001};

    timer_clock_and_clear_select dut (.clk(clk), .srst(srst), .ctrl_we(ctrl_we),
        .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata), .sync_enable(sync_enable),
        .phase_mode(phase_mode), .buffer_c(buffer_c), .buffer_d(buffer_d),
        .match_a(match_a), .match_b(match_b), .match_c(match_c), .match_d(match_d),
        .channel2_counter_ovf(ovf), .channel5_counter_ovf(ovf), .ext_clock_in_a(ext_a),
        .ext_clock_in_b(ext_b), .ext_clock_in_c(ext_c), .ext_clock_in_d(ext_d),
        .count_tick(count_tick), .counter_clear(counter_clear));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // free-running sources: periods 20, 28, 44, 52 and 12 stay apart from prescaler taps
    // ------------------------------------------------------------------
    always @(negedge clk) begin
        cyc <= cyc + 1;
        ext_a <= cyc % 20 < 10;
        ext_b <= cyc % 28 < 14;
        ext_c <= cyc % 44 < 22;
        ext_d <= cyc % 52 < 26;
        ovf <= cyc % 12 == 0;
        if (cyc == 60000) begin
            error_cnt++;
            conclude();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task wr(input int c, input logic [7:0] wd);
        @(negedge clk);
        ctrl_we[c] = 1'b1;
        ctrl_wdata = wd;
        @(negedge clk);
        ctrl_we = '0;
        chk(ctrl_rdata[c], (c % 3 == 0) ? wd : wd & 8'h7f);
    endtask

    task clr(input int c, input logic [7:0] wd, input logic [5:0] ma, mb, mc, md, exp);
        wr(c, wd);
        {match_a, match_b, match_c, match_d} = {ma, mb, mc, md};
        #1 chk(counter_clear, exp);
        @(negedge clk);
        {match_a, match_b, match_c, match_d} = '0;
    endtask

    task conclude();
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        {ctrl_we, sync_enable, phase_mode, buffer_c, buffer_d, ctrl_wdata} = '0;
        {match_a, match_b, match_c, match_d} = '0;
        srst = 1'b1;
        repeat (16) @(negedge clk);
        srst = 1'b0;
        foreach (rows[r]) begin
            ch = rows[r][27:24];
            phase_mode = 6'(rows[r][28]) << ch;
            wr(ch, rows[r][23:16]);
            repeat (16) @(negedge clk);
            ticks = 0;
            repeat (4 * rows[r][15:0]) begin
                @(negedge clk);
                #2 ticks += count_tick[ch];
            end
            want = (rows[r][28] && ch == 2) ? 0 : 4;
            chk(ticks, want);
        end
        phase_mode = '0;
        srst = 1'b1;
        repeat (2) @(negedge clk);
        #2 chk(count_tick, 6'h3f);
        @(negedge clk);
        srst = 1'b0;
        for (int i = 0; i < 6; i++) chk(ctrl_rdata[i], 8'h00);
        clr(0, 8'h20, 6'h01, '0, '0, '0, 6'h01);
        clr(3, 8'h40, 6'h08, '0, '0, '0, 6'h00);
        clr(3, 8'h40, '0, 6'h08, '0, '0, 6'h08);
        clr(0, 8'ha0, '0, '0, 6'h01, '0, 6'h01);
        buffer_c = 6'h01;
        clr(0, 8'ha0, '0, '0, 6'h01, '0, 6'h00);
        clr(3, 8'hc0, '0, '0, '0, 6'h08, 6'h08);
        buffer_d = 6'h08;
        clr(3, 8'hc0, '0, '0, '0, 6'h08, 6'h00);
        clr(0, 8'h80, 6'h01, 6'h01, 6'h01, 6'h01, 6'h00);
        sync_enable = 6'h03;
        clr(1, 8'he0, '0, '0, '0, '0, 6'h00);
        clr(0, 8'h20, 6'h01, '0, '0, '0, 6'h03);
        sync_enable = 6'h0b;
        clr(3, 8'he0, 6'h01, '0, '0, '0, 6'h0b);
        sync_enable = 6'h09;
        clr(3, 8'he0, 6'h01, '0, '0, '0, 6'h09);
        clr(1, 8'h20, 6'h02, '0, '0, '0, 6'h02);
        clr(1, 8'h40, '0, 6'h02, '0, '0, 6'h02);
        conclude();
    end
endmodule

// *** bench/timer_sel_checker.sv ***
// timer_sel_checker.sv: port-level properties of the clock and clear select
// assumes: bound to timer_clock_and_clear_select, one clock, srst synchronous active high
module timer_sel_checker
    import timer_sel_pkg::*;
#(
    parameter int CHANNELS = 6
) (
    input wire logic                clk,
    input wire logic                srst,
    input wire logic [CHANNELS-1:0] ctrl_we,
    input wire logic [7:0]          ctrl_wdata,
    input wire logic [7:0]          ctrl_rdata [CHANNELS],
    input wire logic [CHANNELS-1:0] sync_enable,
    input wire logic [CHANNELS-1:0] phase_mode,
    input wire logic [CHANNELS-1:0] buffer_c,
    input wire logic [CHANNELS-1:0] match_a,
    input wire logic [CHANNELS-1:0] match_b,
    input wire logic [CHANNELS-1:0] match_c,
    input wire logic                channel2_counter_ovf,
    input wire logic [CHANNELS-1:0] count_tick,
    input wire logic [CHANNELS-1:0] counter_clear
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    property p_wr_rsv;
        ctrl_we[1] |=> ctrl_rdata[1] == ($past(ctrl_wdata) & 8'h7f);
    endproperty
    a_wr_rsv: assert property (p_wr_rsv)
        else $error("top clear bit of channel 1 kept");
    property p_clr_a;
        ctrl_rdata[0][7:5] == 3'h1 && match_a[0] |-> counter_clear[0];
    endproperty
    a_clr_a: assert property (p_clr_a)
        else $error("channel 0 not cleared by register a event");
    property p_clr_b;
        ctrl_rdata[3][7:5] == 3'h2 |-> counter_clear[3] == match_b[3];
    endproperty
    a_clr_b: assert property (p_clr_b)
        else $error("channel 3 clear does not follow register b event");
    property p_clr_off;
        ctrl_rdata[0][6:5] == 2'h0 |-> !counter_clear[0];
    endproperty
    a_clr_off: assert property (p_clr_off)
        else $error("channel 0 cleared with clearing disabled");
    property p_clr_buf;
        ctrl_rdata[0][7:5] == 3'h5 |-> counter_clear[0] == (match_c[0] && !buffer_c[0]);
    endproperty
    a_clr_buf: assert property (p_clr_buf)
        else $error("channel 0 register c clear wrong");
    property p_sync_off;
        ctrl_rdata[1][6:5] == 2'h3 && !sync_enable[1] |-> !counter_clear[1];
    endproperty
    a_sync_off: assert property (p_sync_off)
        else $error("channel 1 cleared without sync enable");
    property p_div1;
        ctrl_rdata[0][2:0] == 3'h0 |-> count_tick[0];
    endproperty
    a_div1: assert property (p_div1)
        else $error("undivided clock missed a tick");
    property p_cascade;
        ctrl_rdata[1][2:0] == 3'h7 && !phase_mode[1] |-> count_tick[1] == channel2_counter_ovf;
    endproperty
    a_cascade: assert property (p_cascade)
        else $error("channel 1 cascade tick differs from overflow");
    property p_phase;
        phase_mode[2] |-> !count_tick[2];
    endproperty
    a_phase: assert property (p_phase)
        else $error("channel 2 ticked in phase counting mode");
endmodule

bind timer_clock_and_clear_select timer_sel_checker #(.CHANNELS(CHANNELS)) u_chk (
    .clk(clk), .srst(srst), .ctrl_we(ctrl_we), .ctrl_wdata(ctrl_wdata),
    .ctrl_rdata(ctrl_rdata), .sync_enable(sync_enable), .phase_mode(phase_mode),
    .buffer_c(buffer_c), .match_a(match_a), .match_b(match_b), .match_c(match_c),
    .channel2_counter_ovf(channel2_counter_ovf), .count_tick(count_tick),
    .counter_clear(counter_clear));

// *** hw/edge_counter_channel.sv ***
// edge_counter_channel.sv: one channel's edge detection on its chosen count source
// assumes: source level is already synchronised to clk; cascade pulse is one cycle wide
`include "timer_sel_cfg.svh"
module edge_counter_channel
    import timer_sel_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire logic                 src_level,
    input  wire logic                 bypass_edge,
    input  wire logic [1:0]           edge_sel,
    output logic                      count_tick
);
    logic prev;
    logic next_prev;

    always_comb begin
        next_prev = src_level;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            prev <= 1'b0;
        end else begin
            prev <= next_prev;
        end
    end

    // undivided clock and cascade pulses count as-is; else pick edges
    always_comb begin
        if (bypass_edge) begin
            count_tick = src_level;
        end else if (edge_sel == `EDGE_RISE) begin
            count_tick = src_level & ~prev;
        end else if (edge_sel == `EDGE_FALL) begin
            count_tick = ~src_level & prev;
        end else begin
            count_tick = src_level ^ prev;
        end
    end
endmodule

// *** hw/timer_clock_and_clear_select.sv ***
// timer_clock_and_clear_select.sv: clock source and counter clear selection for six channels
// assumes: match/capture strobes and partner overflow strobes come from same-clock timer logic
`include "timer_sel_cfg.svh"
module timer_clock_and_clear_select
    import timer_sel_pkg::*;
#(
    parameter int CHANNELS = 6
) (
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire logic [CHANNELS-1:0]  ctrl_we,
    input  wire logic [7:0]           ctrl_wdata,
    output logic [7:0]                ctrl_rdata [CHANNELS],
    input  wire logic [CHANNELS-1:0]  sync_enable,
    input  wire logic [CHANNELS-1:0]  phase_mode,
    input  wire logic [CHANNELS-1:0]  buffer_c,
    input  wire logic [CHANNELS-1:0]  buffer_d,
    input  wire logic [CHANNELS-1:0]  match_a,
    input  wire logic [CHANNELS-1:0]  match_b,
    input  wire logic [CHANNELS-1:0]  match_c,
    input  wire logic [CHANNELS-1:0]  match_d,
    input  wire logic                 channel2_counter_ovf,
    input  wire logic                 channel5_counter_ovf,
    input  wire logic                 ext_clock_in_a,
    input  wire logic                 ext_clock_in_b,
    input  wire logic                 ext_clock_in_c,
    input  wire logic                 ext_clock_in_d,
    output logic [CHANNELS-1:0]       count_tick,
    output logic [CHANNELS-1:0]       counter_clear
);
    // -----------------------------------------------------------------------
    // control bytes
    // -----------------------------------------------------------------------
    logic [7:0] ctrl      [CHANNELS];
    logic [7:0] next_ctrl [CHANNELS];

    function automatic logic has_four_regs(input int ch);
        return (ch == 0) || (ch == 3);
    endfunction

    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            next_ctrl[i] = ctrl[i];
            if (ctrl_we[i]) begin
                next_ctrl[i] = ctrl_wdata;
                if (!has_four_regs(i)) begin
                    next_ctrl[i][`CLR_MSB] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < CHANNELS; i++) begin
            if (srst) begin
                ctrl[i] <= `CTRL_RESET;
            end else begin
                ctrl[i] <= next_ctrl[i];
            end
        end
    end

    assign ctrl_rdata = ctrl;

    // -----------------------------------------------------------------------
    // prescaler and pin synchronisers
    // -----------------------------------------------------------------------
    logic [`PRESC_WIDTH-1:0] presc;
    logic [`PRESC_WIDTH-1:0] next_presc;
    logic [3:0]              pin_s1;
    logic [3:0]              pin_s2;
    logic [3:0]              pin_s3;
    logic [3:0]              pin_state;
    logic [3:0]              next_pin_state;

    always_comb begin
        next_presc = presc + `PRESC_WIDTH'(1);
        // a change is accepted only once two late stages agree, filtering one-cycle glitches
        for (int p = 0; p < 4; p++) begin
            next_pin_state[p] = (pin_s2[p] == pin_s3[p]) ? pin_s3[p] : pin_state[p];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            presc     <= '0;
            pin_s1    <= 4'h0;
            pin_s2    <= 4'h0;
            pin_s3    <= 4'h0;
            pin_state <= 4'h0;
        end else begin
            presc     <= next_presc;
            pin_s1    <= {ext_clock_in_d, ext_clock_in_c, ext_clock_in_b, ext_clock_in_a};
            pin_s2    <= pin_s1;
            pin_s3    <= pin_s2;
            pin_state <= next_pin_state;
        end
    end

    // -----------------------------------------------------------------------
    // per-channel source decode
    // -----------------------------------------------------------------------
    function automatic clk_src_t decode_src(input int ch, input logic [2:0] code);
        clk_src_t s;
        s = src_div1;
        case (code[1:0])
            2'h0: s = src_div1;
            2'h1: s = src_div4;
            2'h2: s = src_div16;
            default: s = src_div64;
        endcase
        if (code[2]) begin
            case (ch)
                0: s = clk_src_t'(src_ext_a + 4'(code[1:0]));
                1: s = (code[1:0] == 2'h0) ? src_ext_a :
                       (code[1:0] == 2'h1) ? src_ext_b :
                       (code[1:0] == 2'h2) ? src_div256 : src_cascade;
                2: s = (code[1:0] == 2'h0) ? src_ext_a :
                       (code[1:0] == 2'h1) ? src_ext_b :
                       (code[1:0] == 2'h2) ? src_ext_c : src_div1024;
                3: s = (code[1:0] == 2'h0) ? src_ext_a :
                       (code[1:0] == 2'h1) ? src_div1024 :
                       (code[1:0] == 2'h2) ? src_div256 : src_div4096;
                4: s = (code[1:0] == 2'h0) ? src_ext_a :
                       (code[1:0] == 2'h1) ? src_ext_c :
                       (code[1:0] == 2'h2) ? src_div1024 : src_cascade;
                default: s = (code[1:0] == 2'h0) ? src_ext_a :
                       (code[1:0] == 2'h1) ? src_ext_c :
                       (code[1:0] == 2'h2) ? src_div256 : src_ext_d;
            endcase
        end
        return s;
    endfunction

    logic [CHANNELS-1:0] raw_tick;

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : chan
            clk_src_t src;
            logic     level;
            logic     bypass;

            assign src = decode_src(g, ctrl[g][`CLK_MSB:`CLK_LSB]);

            always_comb begin
                case (src)
                    src_div1:    level = 1'b1;
                    src_div4:    level = presc[`DIV4_BIT];
                    src_div16:   level = presc[`DIV16_BIT];
                    src_div64:   level = presc[`DIV64_BIT];
                    src_div256:  level = presc[`DIV256_BIT];
                    src_div1024: level = presc[`DIV1024_BIT];
                    src_div4096: level = presc[`DIV4096_BIT];
                    src_ext_a:   level = pin_state[0];
                    src_ext_b:   level = pin_state[1];
                    src_ext_c:   level = pin_state[2];
                    src_ext_d:   level = pin_state[3];
                    src_cascade: level = (g == 1) ? channel2_counter_ovf
                                                  : channel5_counter_ovf;
                    default:     level = 1'b0;
                endcase
            end

            assign bypass = (src == src_div1) || (src == src_cascade);

            edge_counter_channel u_edge (
                .clk         (clk),
                .srst        (srst),
                .src_level   (level),
                .bypass_edge (bypass),
                .edge_sel    (ctrl[g][`EDGE_MSB:`EDGE_LSB]),
                .count_tick  (raw_tick[g])
            );

            // phase counting drives the counter elsewhere; the selected clock is dropped on channels 1, 2, 4 and 5
            assign count_tick[g] = (!has_four_regs(g) && phase_mode[g]) ? 1'b0
                                                                        : raw_tick[g];
        end
    endgenerate

    // -----------------------------------------------------------------------
    // clear selection
    // -----------------------------------------------------------------------
    logic [CHANNELS-1:0] own_clear;
    logic [CHANNELS-1:0] wants_sync;
    logic                any_sync_clear;

    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            logic [2:0] c;
            c = ctrl[i][`CLR_MSB:`CLR_LSB];
            own_clear[i]  = 1'b0;
            wants_sync[i] = 1'b0;
            case (c)
                3'h1: own_clear[i] = match_a[i];
                3'h2: own_clear[i] = match_b[i];
                3'h5: own_clear[i] = match_c[i] & ~buffer_c[i];
                3'h6: own_clear[i] = match_d[i] & ~buffer_d[i];
                3'h3, 3'h7: wants_sync[i] = 1'b1;
                default: own_clear[i] = 1'b0;
            endcase
        end
        any_sync_clear = |(own_clear & sync_enable);
        for (int i = 0; i < CHANNELS; i++) begin
            counter_clear[i] = own_clear[i]
                             | (wants_sync[i] & sync_enable[i] & any_sync_clear);
        end
    end
endmodule

// *** hw/timer_sel_cfg.svh ***
// timer_sel_cfg.svh: field positions, codes and prescaler taps for the clock and clear select
// assumes: included by the package and the design modules, nothing else
`ifndef TIMER_SEL_CFG_SVH
`define TIMER_SEL_CFG_SVH

// ---------------------------------------------------------------------------
// control byte field positions
// ---------------------------------------------------------------------------
`define CLR_MSB        7
`define CLR_LSB        5
`define EDGE_MSB       4
`define EDGE_LSB       3
`define CLK_MSB        2
`define CLK_LSB        0

// ---------------------------------------------------------------------------
// prescaler tap bit positions; bit n divides the system clock by two to the n+1
// ---------------------------------------------------------------------------
`define DIV4_BIT       1
`define DIV16_BIT      3
`define DIV64_BIT      5
`define DIV256_BIT     7
`define DIV1024_BIT    9
`define DIV4096_BIT    11
`define PRESC_WIDTH    12

// ---------------------------------------------------------------------------
// edge select codes
// ---------------------------------------------------------------------------
`define EDGE_RISE      2'h0
`define EDGE_FALL      2'h1

`define CTRL_RESET     8'h00

`endif

// *** hw/timer_sel_pkg.sv ***
// timer_sel_pkg.sv: types shared by the clock and clear select design
// assumes: timer_sel_cfg.svh is on the include path
package timer_sel_pkg;
    `include "timer_sel_cfg.svh"

    typedef enum logic [3:0] {
        src_div1    = 4'b0000,
        src_div4    = 4'b0001,
        src_div16   = 4'b0010,
        src_div64   = 4'b0011,
        src_div256  = 4'b0100,
        src_div1024 = 4'b0101,
        src_div4096 = 4'b0110,
        src_ext_a   = 4'b0111,
        src_ext_b   = 4'b1000,
        src_ext_c   = 4'b1001,
        src_ext_d   = 4'b1010,
        src_cascade = 4'b1011
    } clk_src_t;

    typedef enum logic [1:0] {
        clr_none = 2'b00,
        clr_reg  = 2'b01,
        clr_sync = 2'b10
    } clr_kind_t;
endpackage
